// file: logic/pfi_flags.sv
// Peripheral interrupt flag, enable and request logic.
// Assumes event inputs synchronous to the core clock, high for one or
// more cycles; the register port never stalls.
`timescale 1ns/1ns
`default_nettype none

module pfi_flags
    import pfi_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire pfi_bus_req_type i_bus,
    input wire pfi_event_type i_events,
    output logic [7:0] o_rdata,
    output logic o_core_irq,
    output logic o_irq
);

    logic [7:0] ctl_r;
    logic [3:0][7:0] req_r;
    logic [3:0][7:0] en_r;
    logic [4:0] st_r;
    logic [4:0] st_en_r;
    logic [7:0] rdata_r;
    logic core_irq_r;
    logic irq_r;

    logic [3:0][7:0] set_vec;
    logic [3:0] wr_req;
    logic [3:0] wr_en;
    logic wr_ctl;
    logic wr_st_clr;
    logic wr_st_en;
    logic [2:0] ctl_set;
    logic periph_pend;
    logic core_pend;
    logic core_irq_nxt;
    logic [4:0] st_set;
    logic [7:0] rdata_nxt;

    logic capcmp4_flag;
    logic capcmp3_flag;
    logic timer6_match_flag;
    logic timer4_match_flag;
    logic serial2_collision_flag;
    logic serial2_done_flag;
    logic capcmp4_enable;
    logic capcmp3_enable;
    logic timer6_match_enable;
    logic timer4_match_enable;
    logic serial2_collision_enable;
    logic serial2_done_enable;
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic timer0_flag;
    logic timer0_enable;
    logic ext_pin_flag;
    logic ext_pin_enable;
    logic change_flag;
    logic change_enable;
    logic core_src_pend;

    // Write decode
    always_comb begin
        wr_ctl = 1'b0;
        wr_req = 4'h0;
        wr_en = 4'h0;
        wr_st_clr = 1'b0;
        wr_st_en = 1'b0;
        if (i_bus.wr) begin
            if (i_bus.addr == PFI_OFF_INT_CONTROL) begin
                wr_ctl = 1'b1;
            end else if (i_bus.addr == PFI_OFF_REQUEST_1) begin
                wr_req[0] = 1'b1;
            end else if (i_bus.addr == PFI_OFF_REQUEST_2) begin
                wr_req[1] = 1'b1;
            end else if (i_bus.addr == PFI_OFF_REQUEST_3) begin
                wr_req[2] = 1'b1;
            end else if (i_bus.addr == PFI_OFF_REQUEST_4) begin
                wr_req[3] = 1'b1;
            end else if (i_bus.addr == PFI_OFF_ENABLE_1) begin
                wr_en[0] = 1'b1;
            end else if (i_bus.addr == PFI_OFF_ENABLE_2) begin
                wr_en[1] = 1'b1;
            end else if (i_bus.addr == PFI_OFF_ENABLE_3) begin
                wr_en[2] = 1'b1;
            end else if (i_bus.addr == PFI_OFF_ENABLE_4) begin
                wr_en[3] = 1'b1;
            end else if (i_bus.addr == PFI_OFF_IRQ_CLEAR) begin
                wr_st_clr = 1'b1;
            end else if (i_bus.addr == PFI_OFF_IRQ_ENABLE) begin
                wr_st_en = 1'b1;
            end
        end
    end

    // Hardware set vectors per request register
    always_comb begin
        set_vec[0] = i_events.req1_set;
        set_vec[1] = i_events.req2_set;
        set_vec[2] = 8'h00;
        set_vec[3] = 8'h00;
        set_vec[2][PFI_R3_CAPCMP4] = i_events.capcmp4;
        set_vec[2][PFI_R3_CAPCMP3] = i_events.capcmp3;
        set_vec[2][PFI_R3_TIMER6] = i_events.timer6_match;
        set_vec[2][PFI_R3_TIMER4] = i_events.timer4_match;
        set_vec[3][PFI_R4_COLLISION] = i_events.serial2_collision;
        set_vec[3][PFI_R4_DONE] = i_events.serial2_done;
    end

    // Request and enable registers, one pair per index
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pair
            always_ff @(posedge i_core_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    req_r[g] <= PFI_RST_BYTE;
                end else if (wr_req[g]) begin
                    req_r[g] <= ((i_bus.wdata & PFI_REQ_WR_MASK[g])
                        | (req_r[g] & ~PFI_REQ_WR_MASK[g])
                        | set_vec[g]) & PFI_IMPL_MASK[g];
                end else begin
                    req_r[g] <= (req_r[g] | set_vec[g]) & PFI_IMPL_MASK[g];
                end
            end

            always_ff @(posedge i_core_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    en_r[g] <= PFI_RST_BYTE;
                end else if (wr_en[g]) begin
                    en_r[g] <= i_bus.wdata & PFI_IMPL_MASK[g];
                end
            end
        end
    endgenerate

    // Core-side flags of the control register
    always_comb begin
        ctl_set = 3'h0;
        ctl_set[PFI_CTL_T0_FLAG] = i_events.timer0_ovf;
        ctl_set[PFI_CTL_EXT_FLAG] = i_events.ext_pin;
        ctl_set[PFI_CTL_CHG_FLAG] = i_events.change_notify;
    end

    // control enables, bits 7 to 3
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctl_r[7:3] <= PFI_RST_BYTE[7:3];
        end else if (wr_ctl) begin
            ctl_r[7:3] <= i_bus.wdata[7:3];
        end
    end

    // control flags, bits 2 to 0
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctl_r[2:0] <= PFI_RST_BYTE[2:0];
        end else if (wr_ctl) begin
            ctl_r[2:0] <= i_bus.wdata[2:0] | ctl_set;
        end else begin
            ctl_r[2:0] <= ctl_r[2:0] | ctl_set;
        end
    end

    // Named views of the flags and enables
    always_comb begin
        capcmp4_flag = req_r[2][PFI_R3_CAPCMP4];
        capcmp3_flag = req_r[2][PFI_R3_CAPCMP3];
        timer6_match_flag = req_r[2][PFI_R3_TIMER6];
        timer4_match_flag = req_r[2][PFI_R3_TIMER4];
        serial2_collision_flag = req_r[3][PFI_R4_COLLISION];
        serial2_done_flag = req_r[3][PFI_R4_DONE];
        capcmp4_enable = en_r[2][PFI_R3_CAPCMP4];
        capcmp3_enable = en_r[2][PFI_R3_CAPCMP3];
        timer6_match_enable = en_r[2][PFI_R3_TIMER6];
        timer4_match_enable = en_r[2][PFI_R3_TIMER4];
        serial2_collision_enable = en_r[3][PFI_R4_COLLISION];
        serial2_done_enable = en_r[3][PFI_R4_DONE];
        global_irq_enable = ctl_r[PFI_CTL_GLOBAL_EN];
        peripheral_irq_enable = ctl_r[PFI_CTL_PERIPH_EN];
        timer0_flag = ctl_r[PFI_CTL_T0_FLAG];
        timer0_enable = ctl_r[PFI_CTL_T0_EN];
        ext_pin_flag = ctl_r[PFI_CTL_EXT_FLAG];
        ext_pin_enable = ctl_r[PFI_CTL_EXT_EN];
        change_flag = ctl_r[PFI_CTL_CHG_FLAG];
        change_enable = ctl_r[PFI_CTL_CHG_EN];
    end

    always_comb begin
        periph_pend = 1'b0;
        for (int i = 0; i < 2; i++) begin
            periph_pend = periph_pend | (|(req_r[i] & en_r[i]));
        end
        periph_pend = periph_pend
            | (capcmp4_flag & capcmp4_enable)
            | (capcmp3_flag & capcmp3_enable)
            | (timer6_match_flag & timer6_match_enable)
            | (timer4_match_flag & timer4_match_enable)
            | (serial2_collision_flag & serial2_collision_enable)
            | (serial2_done_flag & serial2_done_enable);
        periph_pend = periph_pend & peripheral_irq_enable;
    end

    // Core-side sources of the control register
    always_comb begin
        core_src_pend = (timer0_flag & timer0_enable)
            | (ext_pin_flag & ext_pin_enable)
            | (change_flag & change_enable);
    end

    always_comb begin
        core_pend = periph_pend | core_src_pend;
        core_irq_nxt = core_pend & global_irq_enable;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            core_irq_r <= 1'b0;
        end else begin
            core_irq_r <= core_irq_nxt;
        end
    end

    // Block event status sources
    always_comb begin
        st_set = 5'h00;
        st_set[PFI_ST_COLLISION] = i_events.serial2_collision;
        st_set[PFI_ST_DONE] = i_events.serial2_done;
        st_set[PFI_ST_TIMER] = i_events.timer4_match
            | i_events.timer6_match;
        st_set[PFI_ST_CAPCMP] = i_events.capcmp3 | i_events.capcmp4;
        st_set[PFI_ST_CORE_REQ] = core_irq_nxt & ~core_irq_r;
    end

    // Sticky status, write one to clear, set wins
    genvar s;
    generate
        for (s = 0; s < 5; s++) begin : g_status
            always_ff @(posedge i_core_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    st_r[s] <= PFI_RST_ST[s];
                end else if (st_set[s]) begin
                    st_r[s] <= 1'b1;
                end else if (wr_st_clr && i_bus.wdata[s]) begin
                    st_r[s] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_en_r <= PFI_RST_ST;
        end else if (wr_st_en) begin
            st_en_r <= i_bus.wdata[4:0] & PFI_ST_MASK;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |((st_r | st_set) & st_en_r);
        end
    end

    // Read mux; unmapped and write-only addresses read zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_bus.addr == PFI_OFF_INT_CONTROL) begin
            rdata_nxt = ctl_r;
        end else if (i_bus.addr == PFI_OFF_REQUEST_1) begin
            rdata_nxt = req_r[0];
        end else if (i_bus.addr == PFI_OFF_REQUEST_2) begin
            rdata_nxt = req_r[1];
        end else if (i_bus.addr == PFI_OFF_REQUEST_3) begin
            rdata_nxt = req_r[2];
        end else if (i_bus.addr == PFI_OFF_REQUEST_4) begin
            rdata_nxt = req_r[3];
        end else if (i_bus.addr == PFI_OFF_ENABLE_1) begin
            rdata_nxt = en_r[0];
        end else if (i_bus.addr == PFI_OFF_ENABLE_2) begin
            rdata_nxt = en_r[1];
        end else if (i_bus.addr == PFI_OFF_ENABLE_3) begin
            rdata_nxt = en_r[2];
        end else if (i_bus.addr == PFI_OFF_ENABLE_4) begin
            rdata_nxt = en_r[3];
        end else if (i_bus.addr == PFI_OFF_IRQ_STATUS) begin
            rdata_nxt = {3'h0, st_r};
        end else if (i_bus.addr == PFI_OFF_IRQ_CLEAR) begin
            rdata_nxt = 8'h00;
        end else if (i_bus.addr == PFI_OFF_IRQ_ENABLE) begin
            rdata_nxt = {3'h0, st_en_r};
        end
    end

    // Read data only in the cycle after the strobe
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_r <= PFI_RST_BYTE;
        end else if (i_bus.rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= PFI_RST_BYTE;
        end
    end

    assign o_rdata = rdata_r;
    assign o_core_irq = core_irq_r;
    assign o_irq = irq_r;

endmodule // pfi_flags

`default_nettype wire

// file: logic/pfi_pkg.sv
// Constants and carrier types for the peripheral interrupt flag block.
// Assumes one core clock and a simple strobed register port.
`default_nettype none

package pfi_pkg;

    // Register offsets, one byte register per address
    localparam logic [3:0] PFI_OFF_INT_CONTROL = 4'h0;
    localparam logic [3:0] PFI_OFF_REQUEST_1 = 4'h1;
    localparam logic [3:0] PFI_OFF_REQUEST_2 = 4'h2;
    localparam logic [3:0] PFI_OFF_REQUEST_3 = 4'h3;
    localparam logic [3:0] PFI_OFF_REQUEST_4 = 4'h4;
    localparam logic [3:0] PFI_OFF_ENABLE_1 = 4'h5;
    localparam logic [3:0] PFI_OFF_ENABLE_2 = 4'h6;
    localparam logic [3:0] PFI_OFF_ENABLE_3 = 4'h7;
    localparam logic [3:0] PFI_OFF_ENABLE_4 = 4'h8;
    localparam logic [3:0] PFI_OFF_IRQ_STATUS = 4'h9;
    localparam logic [3:0] PFI_OFF_IRQ_CLEAR = 4'ha;
    localparam logic [3:0] PFI_OFF_IRQ_ENABLE = 4'hb;

    // Implemented bits per request/enable pair; element 0 is pair 1
    localparam logic [3:0][7:0] PFI_IMPL_MASK = {
        8'h03, 8'h3a, 8'hf9, 8'hff};
    // Software-writable request bits; receive/transmit are read only
    localparam logic [3:0][7:0] PFI_REQ_WR_MASK = {
        8'h03, 8'h3a, 8'hf9, 8'hcf};

    // Interrupt control field positions
    localparam int PFI_CTL_GLOBAL_EN = 7;
    localparam int PFI_CTL_PERIPH_EN = 6;
    localparam int PFI_CTL_T0_EN = 5;
    localparam int PFI_CTL_EXT_EN = 4;
    localparam int PFI_CTL_CHG_EN = 3;
    localparam int PFI_CTL_T0_FLAG = 2;
    localparam int PFI_CTL_EXT_FLAG = 1;
    localparam int PFI_CTL_CHG_FLAG = 0;

    // Third request register field positions
    localparam int PFI_R3_CAPCMP4 = 5;
    localparam int PFI_R3_CAPCMP3 = 4;
    localparam int PFI_R3_TIMER6 = 3;
    localparam int PFI_R3_TIMER4 = 1;
    // Fourth request register field positions
    localparam int PFI_R4_COLLISION = 1;
    localparam int PFI_R4_DONE = 0;

    // Block event status bits
    localparam int PFI_ST_COLLISION = 0;
    localparam int PFI_ST_DONE = 1;
    localparam int PFI_ST_TIMER = 2;
    localparam int PFI_ST_CAPCMP = 3;
    localparam int PFI_ST_CORE_REQ = 4;
    localparam logic [4:0] PFI_ST_MASK = 5'h1f;

    // Reset values
    localparam logic [7:0] PFI_RST_BYTE = 8'h00;
    localparam logic [4:0] PFI_RST_ST = 5'h00;

    typedef struct packed {
        logic timer0_ovf;
        logic ext_pin;
        logic change_notify;
        logic [7:0] req1_set;
        logic [7:0] req2_set;
        logic capcmp4;
        logic capcmp3;
        logic timer6_match;
        logic timer4_match;
        logic serial2_collision;
        logic serial2_done;
    } pfi_event_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } pfi_bus_req_type;

endpackage

`default_nettype wire

// file: bench/pfi_event_src.sv
// Model of the peripheral event sources.
// Assumes the bench calls pulse from its own thread.
`timescale 1ns/1ns
`default_nettype none
module pfi_event_src
    import pfi_pkg::*;
(
    input wire logic i_core_clk,
    output var pfi_event_type o_events
);
    initial o_events = '0;
    task automatic pulse(input int idx, input int len);
        @(posedge i_core_clk);
        o_events <= pfi_event_type'(25'h1 << idx);
        repeat (len) @(posedge i_core_clk);
        o_events <= '0;
    endtask
endmodule // pfi_event_src
`default_nettype wire

// file: bench/pfi_flags_monitor.sv
// Port checker of the flag block.
// Assumes binding into pfi_flags.
`timescale 1ns/1ns
`default_nettype none
module pfi_flags_monitor
    import pfi_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire pfi_bus_req_type i_bus,
    input wire pfi_event_type i_events,
    input wire logic [7:0] o_rdata,
    input wire logic o_core_irq,
    input wire logic o_irq
);
    logic ge_r;
    logic rd3;
    logic rd4;
    assign rd3 = i_bus.rd && i_bus.addr == PFI_OFF_REQUEST_3;
    assign rd4 = i_bus.rd && i_bus.addr == PFI_OFF_REQUEST_4;
    // Shadow of the global enable
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            ge_r <= 1'b0;
        else if (i_bus.wr && i_bus.addr == PFI_OFF_INT_CONTROL)
            ge_r <= i_bus.wdata[PFI_CTL_GLOBAL_EN];
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
        else $error("stray read data");
    req3_gaps_a: assert property (
        rd3 |=> (o_rdata & 8'hc5) == 8'h00) else $error("gap bit set");
    timer4_set_a: assert property (
        i_events.timer4_match ##1 rd3 |=> o_rdata[PFI_R3_TIMER4])
        else $error("timer 4 flag lost");
    capcmp4_set_a: assert property (
        i_events.capcmp4 ##1 rd3 |=> o_rdata[PFI_R3_CAPCMP4])
        else $error("capture 4 flag lost");
    collision_set_a: assert property (
        i_events.serial2_collision ##1 rd4 |=> o_rdata[PFI_R4_COLLISION])
        else $error("collision flag lost");
    done_set_a: assert property (
        i_events.serial2_done ##1 rd4 |=> o_rdata[PFI_R4_DONE])
        else $error("done flag lost");
    global_gate_a: assert property (
        !ge_r |=> !o_core_irq) else $error("request while disabled");
    reset_clean_a: assert property (
        $rose(i_reset_n) |=> !o_core_irq && !o_irq) else $error("dirty reset");
endmodule // pfi_flags_monitor
bind pfi_flags pfi_flags_monitor mon (.i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n), .i_bus(i_bus), .i_events(i_events),
    .o_rdata(o_rdata), .o_core_irq(o_core_irq), .o_irq(o_irq));
`default_nettype wire

// file: bench/pfi_flags_tb.sv
// Self-checking bench of the flag block.
// Assumes the event model and bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module pfi_flags_tb
    import pfi_pkg::*;
;
    logic i_core_clk;
    logic i_reset_n;
    pfi_bus_req_type bus;
    pfi_event_type ev;
    logic [7:0] rdata;
    logic core_irq;
    logic irq;
    int miscompares;
    int total_checks;
    pfi_event_src src (.i_core_clk(i_core_clk), .o_events(ev));
    pfi_flags uut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
        .i_bus(bus), .i_events(ev), .o_rdata(rdata),
        .o_core_irq(core_irq), .o_irq(irq));
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge i_core_clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_core_clk);
        bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_core_clk);
        bus <= '0;
        #1 chk(rdata, exp);
    endtask
    // Both request lines, two edges on
    task automatic irqs(input logic [7:0] exp);
        repeat (2) @(posedge i_core_clk);
        #1 chk({6'h00, core_irq, irq}, exp);
    endtask
    task automatic s_flags();
        logic [3:0] a;
        logic [7:0] m;
        for (int i = 0; i < 6; i++) begin
            a = (i < 2) ? PFI_OFF_REQUEST_4 : PFI_OFF_REQUEST_3;
            m = 8'h01 << ((i == 2) ? 1 : i);
            fork
                src.pulse(i, 1);
                begin
                    @(posedge i_core_clk);
                    rd(a, m);
                end
            join
            wr(a, 8'h00);
            rd(a, 8'h00);
        end
    endtask
    task automatic s_regs();
        fork
            src.pulse(2, 1);
            wr(PFI_OFF_REQUEST_3, 8'h00);
        join
        rd(PFI_OFF_REQUEST_3, 8'h02);
        wr(PFI_OFF_REQUEST_3, 8'hff);
        rd(PFI_OFF_REQUEST_3, 8'h3a);
        wr(PFI_OFF_REQUEST_4, 8'hff);
        rd(PFI_OFF_REQUEST_4, 8'h03);
        wr(PFI_OFF_ENABLE_3, 8'hff);
        rd(PFI_OFF_ENABLE_3, 8'h3a);
        irqs(8'h00);
        rd(4'hf, 8'h00);
        @(posedge i_core_clk);
        i_reset_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        rd(PFI_OFF_REQUEST_3, 8'h00);
        rd(PFI_OFF_REQUEST_4, 8'h00);
    endtask
    task automatic s_core();
        wr(PFI_OFF_REQUEST_3, 8'h00);
        wr(PFI_OFF_ENABLE_3, 8'h02);
        src.pulse(2, 3);
        wr(PFI_OFF_INT_CONTROL, 8'h80);
        irqs(8'h00);
        wr(PFI_OFF_INT_CONTROL, 8'hc0);
        irqs(8'h02);
        rd(PFI_OFF_INT_CONTROL, 8'hc0);
        wr(PFI_OFF_REQUEST_3, 8'h00);
        irqs(8'h00);
        wr(PFI_OFF_INT_CONTROL, 8'h00);
        src.pulse(22, 1);
        rd(PFI_OFF_INT_CONTROL, 8'h01);
        wr(PFI_OFF_INT_CONTROL, 8'h89);
        irqs(8'h02);
        wr(PFI_OFF_INT_CONTROL, 8'h00);
    endtask
    task automatic s_status();
        wr(PFI_OFF_IRQ_CLEAR, 8'h1f);
        wr(PFI_OFF_IRQ_ENABLE, 8'h04);
        src.pulse(3, 1);
        irqs(8'h01);
        rd(PFI_OFF_IRQ_STATUS, 8'h04);
        wr(PFI_OFF_IRQ_ENABLE, 8'h00);
        irqs(8'h00);
        wr(PFI_OFF_IRQ_ENABLE, 8'h04);
        wr(PFI_OFF_IRQ_CLEAR, 8'h04);
        irqs(8'h00);
        rd(PFI_OFF_IRQ_STATUS, 8'h00);
    endtask
    task automatic wrap_up();
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        i_reset_n = 1'b0;
        bus = '0;
        miscompares = 0;
        total_checks = 0;
        repeat (3) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        s_flags();
        s_regs();
        s_core();
        s_status();
        wrap_up();
    end
    // Watchdog well past the expected run
    initial begin
        #20000;
        miscompares++;
        wrap_up();
    end
endmodule // pfi_flags_tb
`default_nettype wire
